// File: sdac_pkg.sv
// Package: register map, field positions, reset values and timing for the converter control
package sdac_pkg;

	// ********************************************
	// Register offsets (indices on the plain port)
	// ********************************************
	localparam logic [3:0] OFS_DECIM    = 4'h0;  // Decimation word
	localparam logic [3:0] OFS_MODE     = 4'h1;  // Converter mode
	localparam logic [3:0] OFS_STATUS   = 4'h2;  // Converter status
	localparam logic [3:0] OFS_PCTL_ONE = 4'h3;  // Primary control one
	localparam logic [3:0] OFS_PCTL_TWO = 4'h4;  // Primary control two
	localparam logic [3:0] OFS_AUX_CTL  = 4'h5;  // Aux control
	localparam logic [3:0] OFS_CURSRC   = 4'h6;  // Current source control
	localparam logic [3:0] OFS_CALCMD   = 4'h7;  // Calibration command
	localparam logic [3:0] OFS_CAL_OFS  = 4'h8;  // Primary offset coefficient
	localparam logic [3:0] OFS_CAL_GAIN = 4'h9;  // Primary gain coefficient
	localparam logic [3:0] OFS_AUX_OFS  = 4'hA;  // Aux offset coefficient
	localparam logic [3:0] OFS_AUX_GAIN = 4'hB;  // Aux gain coefficient

	// ********************************************
	// Field positions
	// ********************************************
	localparam int MODE_CHOP_OFF = 3;  // One disables chopping
	localparam int MODE_NOTCH    = 6;  // Sixty hertz notch enable
	localparam int STAT_REFMISS  = 0;  // Reference missing
	localparam int STAT_ERR_PRI  = 1;  // Primary calibration error
	localparam int STAT_ERR_AUX  = 2;  // Aux calibration error
	localparam int STAT_BUSY     = 3;  // Calibration running
	localparam int STAT_RDY_PRI  = 4;  // Primary result ready (sticky)
	localparam int CURSRC_BURN   = 6;  // Burnout current enable
	localparam int AUXCTL_REFSEL = 6;  // Aux band gap select
	localparam int PCTL2_REFSEL  = 6;  // Primary select, 2 bits [7:6]
	localparam int PCTL1_BUF     = 4;  // Buffer select, 2 bits [5:4]
	localparam int PCTL1_PAIR    = 0;  // Pair code, 4 bits [3:0]
	localparam int PCTL1_DIFF    = 7;  // Differential mode

	// ********************************************
	// Values and limits
	// ********************************************
	localparam logic [7:0] DECIM_RST      = 8'h45;  // Decimal 69
	localparam logic [7:0] DECIM_MIN_CHOP = 8'h0D;  // 13 with chop on
	localparam logic [7:0] DECIM_MIN_NOCH = 8'h03;  // 3 with chop off
	localparam logic [7:0] NOTCH_MIN      = 8'h44;  // 68
	localparam logic [7:0] PAIR_FIVE_SIX  = 8'h04;  // Pair code of inputs 5/6
	localparam logic [7:0] PAIR_SEVEN_EIGHT = 8'h06;  // Pair code of inputs 7/8
	localparam logic [1:0] BUF_BYPASS     = 2'h2;  // Buffer select code for bypass
	localparam logic [1:0] REF_BANDGAP    = 2'h0;  // Primary: internal band gap
	localparam logic [1:0] REF_PRIMARY    = 2'h1;  // Primary: primary pair
	localparam logic [1:0] REF_SECONDARY  = 2'h2;  // Primary: secondary pair
	localparam logic [23:0] CLAMP_VALUE   = 24'hFF_FFFF;  // Result when reference absent

	// Modulator clock divide: 100 MHz core / 32.768 kHz, rounded down
	localparam real CLK_MHZ = 100.0;
	localparam real MOD_KHZ = 32.768;
	localparam int  MOD_DIV = int'($floor(CLK_MHZ * 1000.0 / MOD_KHZ));
	localparam int  MOD_SAMPLES_PER_STEP = 8;  // Results every 8*word samples

	// Calibration command encodings
	typedef enum logic [1:0] {
		SDAC_CAL_NONE, SDAC_CAL_OFS, SDAC_CAL_GAIN
	} sdac_cal_e;

	// Reference selection sent to the analog side
	typedef struct packed {
		logic [1:0] pri_sel;   // Primary converter reference
		logic       aux_bgap;  // Aux on band gap
	} sdac_ref_s;

	// Burnout source drive
	typedef struct packed {
		logic pair_five_six;
		logic pair_seven_eight;
	} sdac_burn_s;

endpackage

// File: sdac_decim.sv
// Decimation pacer: counts modulator samples and marks the end of a conversion
`timescale 1ns/1ps
module sdac_decim (
	input  wire logic       i_ref_clk,   // Core clock
	input  wire logic       i_sys_rst,   // Synchronous reset
	input  wire logic       i_ce,        // Clock enable
	input  wire logic [7:0] i_word,      // Effective decimation word
	output logic            o_mod_tick,  // One pulse per modulator sample
	output logic            o_done       // One pulse per finished conversion
);

	// ********************************************
	// Counters
	// ********************************************
	logic [15:0] div_r, div_nxt;   // Core cycles per sample
	logic [10:0] smp_r, smp_nxt;   // Samples per conversion
	logic        tick_r, tick_nxt;
	logic        done_r, done_nxt;
	logic [10:0] smp_last;         // 8*word - 1

	assign smp_last = {i_word, 3'b000} - 11'd1;

	// Next-state of the pacer
	always_comb begin
		div_nxt  = div_r + 16'd1;
		tick_nxt = 1'b0;
		smp_nxt  = smp_r;
		done_nxt = 1'b0;
		if (div_r == 16'(sdac_pkg::MOD_DIV - 1)) begin
			div_nxt  = '0;
			tick_nxt = 1'b1;
			// Compare with >= so a shrunk word cannot strand the count
			if (smp_r >= smp_last) begin
				smp_nxt  = '0;
				done_nxt = 1'b1;
			end else begin
				smp_nxt = smp_r + 11'd1;
			end
		end
	end

	// Registers only
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			div_r  <= '0;
			smp_r  <= '0;
			tick_r <= 1'b0;
			done_r <= 1'b0;
		end else if (i_ce) begin
			div_r  <= div_nxt;
			smp_r  <= smp_nxt;
			tick_r <= tick_nxt;
			done_r <= done_nxt;
		end
	end

	assign o_mod_tick = tick_r & i_ce;
	assign o_done     = done_r & i_ce;

endmodule

// File: sdac_ctrl.sv
// Sigma-delta converter control: registers, word range, reference detect, calibration guard
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module sdac_ctrl (
	input  wire logic        i_ref_clk,      // Core clock, 100 MHz
	input  wire logic        i_sys_rst,      // Synchronous reset, high
	input  wire logic        i_ce,           // Clock enable, freezes all state
	input  wire logic [3:0]  i_addr,         // Register index
	input  wire logic [7:0]  i_wdata,        // Write data
	input  wire logic        i_wr,           // Write strobe
	input  wire logic        i_rd,           // Read strobe
	output logic      [7:0]  o_rdata,        // Read data, cycle after strobe
	input  wire logic        i_ref_ok_pin,   // Primary pair above threshold
	input  wire logic [23:0] i_filt_data,    // Raw sinc output from datapath
	output logic      [23:0] o_result,       // Result after clamping
	output logic             o_result_vld,   // Result pulse
	output logic      [7:0]  o_decim_eff,    // Effective decimation factor
	output logic             o_chop_en,      // Chopping active
	output logic             o_notch_en,     // Sixty hertz notch active
	output logic             o_mod_tick,     // Modulator sample strobe
	output sdac_pkg::sdac_ref_s  o_ref_sel,  // Reference routing
	output sdac_pkg::sdac_burn_s o_burn      // Burnout source drive
);
	// Assertions all run on the core clock and rest during reset
	default clocking cb_core @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	// ********************************************
	// Registers
	// ********************************************
	logic [7:0]  decim_r, decim_nxt;     // Decimation word
	logic [7:0]  mode_r, mode_nxt;       // Converter mode
	logic [7:0]  pctl1_r, pctl1_nxt;     // Primary control one
	logic [7:0]  pctl2_r, pctl2_nxt;     // Primary control two
	logic [7:0]  auxc_r, auxc_nxt;       // Aux control
	logic [7:0]  isrc_r, isrc_nxt;       // Current source control
	logic [23:0] coef_r [4], coef_nxt [4];  // Offset/gain coefficients
	logic        miss_r, miss_nxt;       // Reference missing flag
	logic        err_pri_r, err_pri_nxt; // Primary calibration error
	logic        err_aux_r, err_aux_nxt; // Aux calibration error
	logic        rdy_r, rdy_nxt;         // Result ready, sticky
	logic [7:0]  rdata_r, rdata_nxt;
	logic [23:0] res_r, res_nxt;
	logic        resv_r, resv_nxt;

	// Calibration sequencer
	typedef enum logic [1:0] {CAL_IDLE, CAL_RUN} sdac_cst_e;
	sdac_cst_e   cst_r, cst_nxt;
	logic [1:0]  ckind_r, ckind_nxt;     // Which coefficient
	logic        caux_r, caux_nxt;       // Aux converter target
	logic        cbad_r, cbad_nxt;       // Reference lost during run

	// ********************************************
	// Pin synchroniser, three stages
	// ********************************************
	logic [2:0]  ref_sync_r;
	logic        ref_ok_r;               // Filtered level

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			ref_sync_r <= 3'b111;
			ref_ok_r   <= 1'b1;
		end else if (i_ce) begin
			ref_sync_r <= {ref_sync_r[1:0], i_ref_ok_pin};
			// Change accepted once stages two and three agree
			if (ref_sync_r[1] == ref_sync_r[2]) begin
				ref_ok_r <= ref_sync_r[2];
			end
		end
	end

	// ********************************************
	// Derived controls
	// ********************************************
	logic       chop_on, done;
	logic [7:0] word_eff;
	logic       wr_cal;
	assign chop_on = ~mode_r[sdac_pkg::MODE_CHOP_OFF];

	// Clamp the low end; the top of 255 is the register's own limit
	always_comb begin
		if (chop_on && decim_r < sdac_pkg::DECIM_MIN_CHOP) begin
			word_eff = sdac_pkg::DECIM_MIN_CHOP;
		end else if (!chop_on && decim_r < sdac_pkg::DECIM_MIN_NOCH) begin
			word_eff = sdac_pkg::DECIM_MIN_NOCH;
		end else begin
			word_eff = decim_r;
		end
	end
	// Same word feeds normal and calibration conversions
	sdac_decim u_decim (
		.i_ref_clk  (i_ref_clk),
		.i_sys_rst  (i_sys_rst),
		.i_ce       (i_ce),
		.i_word     (word_eff),
		.o_mod_tick (o_mod_tick),
		.o_done     (done)
	);
	assign wr_cal = i_wr && (i_addr == sdac_pkg::OFS_CALCMD);

	// ********************************************
	// Next-state: registers, flags, calibration
	// ********************************************
	always_comb begin
		decim_nxt   = decim_r;
		mode_nxt    = mode_r;
		pctl1_nxt   = pctl1_r;
		pctl2_nxt   = pctl2_r;
		auxc_nxt    = auxc_r;
		isrc_nxt    = isrc_r;
		coef_nxt    = coef_r;
		err_pri_nxt = err_pri_r;
		err_aux_nxt = err_aux_r;
		rdy_nxt     = rdy_r;
		cst_nxt     = cst_r;
		ckind_nxt   = ckind_r;
		caux_nxt    = caux_r;
		cbad_nxt    = cbad_r;
		res_nxt     = res_r;
		resv_nxt    = 1'b0;
		// Only the primary pair detector drives the flag
		miss_nxt    = ~ref_ok_r;
		rdata_nxt   = '0;
		// Software writes
		if (i_wr) begin
			case (i_addr)
				sdac_pkg::OFS_DECIM:    decim_nxt = i_wdata;
				sdac_pkg::OFS_MODE:     mode_nxt  = i_wdata;
				sdac_pkg::OFS_PCTL_ONE: pctl1_nxt = i_wdata;
				sdac_pkg::OFS_PCTL_TWO: pctl2_nxt = i_wdata;
				sdac_pkg::OFS_AUX_CTL:  auxc_nxt  = i_wdata;
				sdac_pkg::OFS_CURSRC:   isrc_nxt  = i_wdata;
				default: ;
			endcase
		end
		// Software clears the sticky ready bit by reading status; new events win below
		if (i_rd && i_addr == sdac_pkg::OFS_STATUS) begin
			rdy_nxt = 1'b0;
		end
		// Conversion finished: publish, clamped if the reference is gone
		if (done) begin
			res_nxt  = ref_ok_r ? i_filt_data : sdac_pkg::CLAMP_VALUE;
			resv_nxt = 1'b1;
			rdy_nxt  = 1'b1;
		end
		// Calibration sequencer
		case (cst_r)
			CAL_IDLE: begin
				if (wr_cal && i_wdata[1:0] != 2'(sdac_pkg::SDAC_CAL_NONE)) begin
					cst_nxt   = CAL_RUN;
					ckind_nxt = i_wdata[1:0];
					caux_nxt  = i_wdata[2];
					cbad_nxt  = ~ref_ok_r;
					// Fresh run clears the converter's old error
					if (i_wdata[2]) begin
						err_aux_nxt = 1'b0;
					end else begin
						err_pri_nxt = 1'b0;
					end
				end
			end
			CAL_RUN: begin
				if (!ref_ok_r) begin
					cbad_nxt = 1'b1;
				end
				if (done) begin
					cst_nxt = CAL_IDLE;
					if (cbad_r || !ref_ok_r) begin
						// Coefficient kept, error raised
						if (caux_r) begin
							err_aux_nxt = 1'b1;
						end else begin
							err_pri_nxt = 1'b1;
						end
					end else begin
						coef_nxt[{caux_r, ckind_r == 2'(sdac_pkg::SDAC_CAL_GAIN)}] =
							i_filt_data;
					end
				end
			end
			default: cst_nxt = CAL_IDLE;
		endcase
		// Read mux
		if (i_rd) begin
			case (i_addr)
				sdac_pkg::OFS_DECIM:    rdata_nxt = decim_r;
				sdac_pkg::OFS_MODE:     rdata_nxt = mode_r;
				sdac_pkg::OFS_STATUS: begin
					rdata_nxt[sdac_pkg::STAT_REFMISS] = miss_r;
					rdata_nxt[sdac_pkg::STAT_ERR_PRI] = err_pri_r;
					rdata_nxt[sdac_pkg::STAT_ERR_AUX] = err_aux_r;
					rdata_nxt[sdac_pkg::STAT_BUSY]    = (cst_r == CAL_RUN);
					rdata_nxt[sdac_pkg::STAT_RDY_PRI] = rdy_r;
				end
				sdac_pkg::OFS_PCTL_ONE: rdata_nxt = pctl1_r;
				sdac_pkg::OFS_PCTL_TWO: rdata_nxt = pctl2_r;
				sdac_pkg::OFS_AUX_CTL:  rdata_nxt = auxc_r;
				sdac_pkg::OFS_CURSRC:   rdata_nxt = isrc_r;
				sdac_pkg::OFS_CAL_OFS:  rdata_nxt = coef_r[0][23:16];
				sdac_pkg::OFS_CAL_GAIN: rdata_nxt = coef_r[1][23:16];
				sdac_pkg::OFS_AUX_OFS:  rdata_nxt = coef_r[2][23:16];
				sdac_pkg::OFS_AUX_GAIN: rdata_nxt = coef_r[3][23:16];
				default:                rdata_nxt = '0;
			endcase
		end
	end

	// Registers only
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			decim_r   <= sdac_pkg::DECIM_RST;
			mode_r    <= '0;
			pctl1_r   <= '0;
			pctl2_r   <= {sdac_pkg::REF_PRIMARY, 6'h00};
			auxc_r    <= '0;
			isrc_r    <= '0;
			coef_r    <= '{default: '0};
			miss_r    <= 1'b0;
			err_pri_r <= 1'b0;
			err_aux_r <= 1'b0;
			rdy_r     <= 1'b0;
			rdata_r   <= '0;
			res_r     <= '0;
			resv_r    <= 1'b0;
			cst_r     <= CAL_IDLE;
			ckind_r   <= '0;
			caux_r    <= 1'b0;
			cbad_r    <= 1'b0;
		end else if (i_ce) begin
			decim_r   <= decim_nxt;
			mode_r    <= mode_nxt;
			pctl1_r   <= pctl1_nxt;
			pctl2_r   <= pctl2_nxt;
			auxc_r    <= auxc_nxt;
			isrc_r    <= isrc_nxt;
			coef_r    <= coef_nxt;
			miss_r    <= miss_nxt;
			err_pri_r <= err_pri_nxt;
			err_aux_r <= err_aux_nxt;
			rdy_r     <= rdy_nxt;
			rdata_r   <= rdata_nxt;
			res_r     <= res_nxt;
			resv_r    <= resv_nxt;
			cst_r     <= cst_nxt;
			ckind_r   <= ckind_nxt;
			caux_r    <= caux_nxt;
			cbad_r    <= cbad_nxt;
		end
	end

	// ********************************************
	// Outputs to the analog side
	// ********************************************
	logic       buf_on, diff_on;
	logic [7:0] pair_code;
	assign buf_on    = pctl1_r[sdac_pkg::PCTL1_BUF +: 2] != sdac_pkg::BUF_BYPASS;
	assign diff_on   = pctl1_r[sdac_pkg::PCTL1_DIFF];
	assign pair_code = {4'h0, pctl1_r[sdac_pkg::PCTL1_PAIR +: 4]};

	// Burnout sources need the enable, a buffered differential input and a legal pair
	assign o_burn.pair_five_six = isrc_r[sdac_pkg::CURSRC_BURN] & buf_on & diff_on
		& (pair_code == sdac_pkg::PAIR_FIVE_SIX);
	assign o_burn.pair_seven_eight = isrc_r[sdac_pkg::CURSRC_BURN] & buf_on & diff_on
		& (pair_code == sdac_pkg::PAIR_SEVEN_EIGHT);

	// Primary: either pair or band gap; aux: primary pair or band gap
	assign o_ref_sel.pri_sel  = pctl2_r[sdac_pkg::PCTL2_REFSEL +: 2];
	assign o_ref_sel.aux_bgap = auxc_r[sdac_pkg::AUXCTL_REFSEL];

	assign o_notch_en   = mode_r[sdac_pkg::MODE_NOTCH];
	assign o_chop_en    = chop_on;
	assign o_decim_eff  = word_eff;
	assign o_rdata      = rdata_r;
	assign o_result     = res_r;
	assign o_result_vld = resv_r;

	// ********************************************
	// Assertions
	// ********************************************
	property p_word_floor;
		chop_on |-> o_decim_eff >= 8'd13;
	endproperty
	a_word_floor: assert property (p_word_floor) else $error("chop word below 13");
	property p_word_nochop;
		(!chop_on && decim_r >= 8'd3) |-> o_decim_eff == decim_r;
	endproperty
	a_word_nochop: assert property (p_word_nochop) else $error("chop-off word altered");
	property p_readback;
		(i_ce && i_wr && i_addr == 4'h0) ##1 (i_ce && i_rd && i_addr == 4'h0 && !i_wr)
		|=> o_rdata == $past(i_wdata, 2);
	endproperty
	a_readback: assert property (p_readback) else $error("word readback mismatch");
	property p_clamp;
		(done && !ref_ok_r) |=> o_result_vld && o_result == 24'hFF_FFFF;
	endproperty
	a_clamp: assert property (p_clamp) else $error("result not clamped");
	sequence s_cal_bad_end;
		cst_r == CAL_RUN && done && !ref_ok_r && !caux_r;
	endsequence
	property p_cal_err;
		s_cal_bad_end |=> err_pri_r && $stable(coef_r[0]) && $stable(coef_r[1]);
	endproperty
	a_cal_err: assert property (p_cal_err) else $error("bad calibration wrote coefficient");
	property p_burn;
		(o_burn.pair_five_six || o_burn.pair_seven_eight) |-> buf_on && diff_on;
	endproperty
	a_burn: assert property (p_burn) else $error("burnout without buffer");
	property p_chop_bit;
		o_chop_en == !mode_r[3];
	endproperty
	a_chop_bit: assert property (p_chop_bit) else $error("chop bit inverted");
	property p_reset_word;
		$fell(i_sys_rst) |-> decim_r == 8'd69;
	endproperty
	a_reset_word: assert property (p_reset_word) else $error("reset word not 69");
endmodule

// File: sdac_front_model.sv
// Far-side model: primary reference comparator and sinc filter word
`timescale 1ns/1ps
module sdac_front_model #(
	parameter logic [23:0] FILT_VAL = 24'h00_0000  // Filter word presented
) (
	input  wire logic        i_clk,         // Core clock
	input  wire logic        i_ref_on,      // Bench command: pair connected
	input  wire logic        i_mod_tick,    // Modulator sample strobe
	output logic             o_ref_ok_pin,  // Comparator level
	output logic      [23:0] o_filt_data    // Filter word
);
	// ****************
	// Analog side
	// ****************
	initial begin
		o_ref_ok_pin = 1'b1;
		o_filt_data = FILT_VAL;
	end

	// Comparator lags the cable by one cycle, like a slow front end
	always @(posedge i_clk) begin
		o_ref_ok_pin <= i_ref_on;
	end

	// Word moves only on modulator samples at the fixed rate
	always @(posedge i_clk) begin
		if (i_mod_tick === 1'b1) begin
			o_filt_data <= FILT_VAL;
		end
	end
endmodule

// File: test_sigma_delta_adc_control.sv
// Bench for the sigma-delta converter control block
`timescale 1ns/1ps
module test_sigma_delta_adc_control;
	// ****************
	// Signals
	// ****************
	localparam logic [23:0] FILT = 24'hA5_5A3C;  // Model filter word
	logic        clk = 1'b0;     // Core clock
	logic        rst = 1'b1;     // Sync reset
	logic        ce = 1'b1;      // Held on
	logic [3:0]  addr = 4'h0;    // Register index
	logic [7:0]  wdata = 8'h00;  // Write data
	logic        wr = 1'b0;      // Write strobe
	logic        rd = 1'b0;      // Read strobe
	logic        ref_on = 1'b1;  // Cable connected
	logic [7:0]  rdata;
	logic        ref_ok;
	logic [23:0] filt;
	logic [23:0] result;
	logic        vld;
	logic [7:0]  deff;
	logic        chop;
	logic        notch;
	logic        tick;
	sdac_pkg::sdac_ref_s  rsel;
	sdac_pkg::sdac_burn_s burn;
	int          err_total = 0;
	int          n_tests = 0;

	initial begin
		forever #5 clk = ~clk;
	end

	sdac_ctrl dut_u (.i_ref_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ref_ok_pin(ref_ok),
		.i_filt_data(filt), .o_result(result), .o_result_vld(vld), .o_decim_eff(deff),
		.o_chop_en(chop), .o_notch_en(notch), .o_mod_tick(tick), .o_ref_sel(rsel),
		.o_burn(burn));

	sdac_front_model #(.FILT_VAL(FILT)) model_u (.i_clk(clk), .i_ref_on(ref_on),
		.i_mod_tick(tick), .o_ref_ok_pin(ref_ok), .o_filt_data(filt));

	// ****************
	// Shared tasks
	// ****************
	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One-cycle write; strobe drops at the taking edge
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// Write then read back with no idle cycle between the strobes
	task automatic wr_rd(input logic [3:0] a, input logic [7:0] dw, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= dw;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// Let a write land and outputs settle
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset;
		logic [7:0] r;
		rd_reg(sdac_pkg::OFS_DECIM, r);
		chk("reset word", r, 8'h45);
		chk("reset chop", chop, 1'b1);
		chk("reset notch", notch, 1'b0);
		chk("reset pri sel", rsel.pri_sel, sdac_pkg::REF_PRIMARY);
		chk("reset burn", burn, 2'b00);
	endtask

	// Offset calibration at word 3, chop off, reference pulled mid-run and before the end
	task automatic t_convert;
		logic [7:0] s;
		int ticks;
		int last;
		int per;
		int cyc;
		logic seen;
		ticks = 0;
		last = 0;
		per = 0;
		cyc = 0;
		seen = 1'b0;
		wr_reg(sdac_pkg::OFS_MODE, 8'h08);
		wr_reg(sdac_pkg::OFS_DECIM, 8'h03);
		wr_reg(sdac_pkg::OFS_CALCMD, 8'h01);
		ref_on <= 1'b0;
		repeat (6) @(posedge clk);
		rd_reg(sdac_pkg::OFS_STATUS, s);
		chk("status missing busy", s, 8'h09);
		ref_on <= 1'b1;
		// Watch every cycle until the one-cycle result pulse of the conversion
		while (!seen && cyc < 80000) begin
			@(posedge clk);
			#1;
			cyc++;
			if (vld === 1'b1) begin
				seen = 1'b1;
				// Reference is away at the end, so the result is clamped
				chk("result", result, sdac_pkg::CLAMP_VALUE);
			end
			if (tick === 1'b1) begin
				if (ticks > 0) begin
					per = cyc - last;
				end
				last = cyc;
				ticks++;
			end
			// Cable pulled again one sample before the last
			if (ticks == 8 * 3 - 1) begin
				ref_on <= 1'b0;
			end
		end
		chk("tick period", per, sdac_pkg::MOD_DIV);
		chk("samples per result", ticks, 8 * 3);
		chk("conversion ended", seen, 1'b1);
		// Flag still up while the reference stays away
		rd_reg(sdac_pkg::OFS_STATUS, s);
		chk("cal error missing", s & 8'h0F, 8'h03);
		ref_on <= 1'b1;
		repeat (10) @(posedge clk);
		// Only the primary calibration error bit reads after the calibration
		rd_reg(sdac_pkg::OFS_STATUS, s);
		chk("cal error", s & 8'h0F, 8'h02);
		rd_reg(sdac_pkg::OFS_CAL_OFS, s);
		chk("coeff kept", s, 8'h00);
	endtask

	// Word range with chop on and off, plus readback
	task automatic t_range;
		logic [7:0] w [6] = '{8'h00, 8'h02, 8'h03, 8'h0C, 8'h0D, 8'hFF};
		logic [7:0] r;
		logic [7:0] lo;
		for (int m = 0; m < 2; m++) begin
			wr_reg(sdac_pkg::OFS_MODE, (m == 1) ? 8'h08 : 8'h00);
			lo = (m == 1) ? sdac_pkg::DECIM_MIN_NOCH : sdac_pkg::DECIM_MIN_CHOP;
			for (int i = 0; i < 6; i++) begin
				wr_rd(sdac_pkg::OFS_DECIM, w[i], r);
				chk("word readback", r, w[i]);
				chk("eff word", deff, (w[i] < lo) ? lo : w[i]);
				chk("chop", chop, (m == 1) ? 1'b0 : 1'b1);
			end
		end
	endtask

	// Notch follows mode bit 6 alone; the word is set to 0x52 first
	task automatic t_notch;
		wr_reg(sdac_pkg::OFS_DECIM, 8'h52);
		wr_reg(sdac_pkg::OFS_MODE, 8'h40);
		settle();
		chk("notch on", notch, 1'b1);
		wr_reg(sdac_pkg::OFS_MODE, 8'h00);
		settle();
		chk("notch off", notch, 1'b0);
	endtask

	task automatic t_refsel;
		for (int c = 0; c < 3; c++) begin
			wr_reg(sdac_pkg::OFS_PCTL_TWO, {c[1:0], 6'h00});
			settle();
			chk("pri sel", rsel.pri_sel, c[1:0]);
		end
		wr_reg(sdac_pkg::OFS_AUX_CTL, 8'h40);
		settle();
		chk("aux band gap", rsel.aux_bgap, 1'b1);
		wr_reg(sdac_pkg::OFS_AUX_CTL, 8'h00);
		settle();
		chk("aux pair", rsel.aux_bgap, 1'b0);
	endtask

	// Burnout drive across pair, mode, buffer and enable
	// Full scale then means open sensor, zero means short
	task automatic t_burn;
		logic [7:0] ic [6] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'h00, 8'h40};
		logic [7:0] p1 [6] = '{8'h84, 8'h86, 8'h06, 8'hA4, 8'h84, 8'h85};
		logic [1:0] ex [6] = '{2'b10, 2'b01, 2'b00, 2'b00, 2'b00, 2'b00};
		for (int i = 0; i < 6; i++) begin
			wr_reg(sdac_pkg::OFS_CURSRC, ic[i]);
			wr_reg(sdac_pkg::OFS_PCTL_ONE, p1[i]);
			settle();
			chk("burnout", burn, ex[i]);
		end
	endtask

	// Unmapped index reads zero
	task automatic t_bus;
		logic [7:0] r;
		rd_reg(4'hF, r);
		chk("unmapped", r, 8'h00);
	endtask

	// ****************
	// Sequence
	// ****************
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_convert();
		t_range();
		t_notch();
		t_refsel();
		t_burn();
		t_bus();
		close_out();
	end

	// Whole run is one conversion at word 3 plus short register work
	initial begin
		repeat (95000) @(posedge clk);
		err_total++;
		close_out();
	end
endmodule
